/* File: rtl/eight_bit_timer_compare_core.sv */
// eight-bit timer/counter with two output compare channels
// Function
// - zero count is bottom, flagged
// - 0xff count signals maximum
// - top is 0xff or compare a
// - tick from io clock or crystal
// - clock select zero stops ticks
// - count readable at any time, writable unless powered off
// - software count write beats counting
// - each tick clears, increments or decrements per mode
// - continuous equality compare per channel
// - match flag set on following tick
// - match flag cleared by service or one
// - flags in one register, masked interrupts
// - compare double buffered in pwm modes
// - software reaches buffer or active value
// - force strobe updates output only, in non-pwm modes
// - count write blocks next tick matches
// - output state kept across mode change
// - output mode bits act immediately
// - power off bit disables module
// - overflow flag per mode, interrupt source
// - mode 0 wraps, overflow at zero
// - mode 2 clears on compare a
// - modes 3 and 7 single slope
// - output mode zero takes no action
`timescale 1ns/100ps
module eight_bit_timer_compare_core (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_crystal_pin_in,
  output logic [7:0]      o_rdata,
  output logic            o_wave_output_a,
  output logic            o_wave_output_b,
  output logic            o_irq_overflow,
  output logic            o_irq_match_a,
  output logic            o_irq_match_b,
  output logic            o_crystal_pin_out
);
  import timer_core_pkg::*;

  typedef struct packed {
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic [7:0] count_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buffer_a;
    logic [7:0] buffer_b;
    logic [2:0] flags;
    logic [2:0] mask;
    logic       async_clock_select;
    logic       timer_power_off;
    logic       count_down;
    logic       block_match;
    logic       pend_a;
    logic       pend_b;
    logic       wave_a;
    logic       wave_b;
    logic [1:0] xtal_sync;
    logic       xtal_last;
    logic       osc_out;
    logic [7:0] rdata;
    logic [2:0] irq;
  } state_type;

  state_type st;
  state_type nx;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == MODE_PHASE) || (m == MODE_FAST) || (m == MODE_PHASE_A) || (m == MODE_FAST_A);
  endfunction

  function automatic logic apply_com(input logic [1:0] com, input logic cur);
    case (com)
      COM_TOGGLE: apply_com = ~cur;
      COM_CLEAR:  apply_com = 1'b0;
      COM_SET:    apply_com = 1'b1;
      default:    apply_com = cur;
    endcase
  endfunction

  logic [2:0] waveform_mode;
  logic [2:0] clock_source_select;
  logic       buffered;
  logic       timer_tick;
  logic       xtal_rise;
  logic [7:0] top_value;
  logic       at_top;
  logic       at_bottom;
  logic       at_max;
  logic       eq_a;
  logic       eq_b;
  logic       wr_count;

  always_comb begin
    waveform_mode       = {st.control_b[POS_MODE_BIT2], st.control_a[POS_MODE_BIT1], st.control_a[POS_MODE_BIT0]};
    clock_source_select = st.control_b[POS_CLK_SEL +: 3];
    buffered            = is_pwm(waveform_mode);
    xtal_rise           = st.xtal_sync[1] & ~st.xtal_last;
    timer_tick = ~st.timer_power_off && (clock_source_select != CLK_STOPPED)
                 && (st.async_clock_select ? xtal_rise : 1'b1);
    top_value  = (waveform_mode == MODE_FAST_A || waveform_mode == MODE_PHASE_A)
                 ? st.compare_value_a : COUNT_MAX;
    at_top     = st.count_value == top_value;
    at_bottom  = st.count_value == COUNT_BOTTOM;
    at_max     = st.count_value == COUNT_MAX;
    eq_a       = st.count_value == st.compare_value_a;
    eq_b       = st.count_value == st.compare_value_b;
    wr_count   = i_wr && (i_addr == ADDR_COUNT) && ~st.timer_power_off;
  end

  always_comb begin
    logic [2:0] set_f;
    logic [2:0] clr_f;
    logic [7:0] rd;
    nx    = st;
    set_f = 3'h0;
    clr_f = 3'h0;
    rd    = RESET_BYTE;
    nx.xtal_sync = {st.xtal_sync[0], i_crystal_pin_in};
    nx.xtal_last = st.xtal_sync[1];
    nx.osc_out   = st.async_clock_select & ~st.xtal_sync[1];

    if (timer_tick) begin
      // matches seen on the previous tick raise flags now
      set_f[POS_MATCH_A] = st.pend_a;
      set_f[POS_MATCH_B] = st.pend_b;
      nx.pend_a = eq_a && ~st.block_match;
      nx.pend_b = eq_b && ~st.block_match;
      if (eq_a && ~st.block_match) begin
        nx.wave_a = apply_com(st.control_a[POS_COM_A +: 2], st.wave_a);
      end
      if (eq_b && ~st.block_match) begin
        nx.wave_b = apply_com(st.control_a[POS_COM_B +: 2], st.wave_b);
      end
      nx.block_match = 1'b0;
      case (waveform_mode)
        MODE_NORMAL: begin
          nx.count_value = st.count_value + 8'h01;
          if (at_max) set_f[POS_OVERFLOW] = 1'b1;
        end
        MODE_CLEAR_ON_MATCH: begin
          if (eq_a) nx.count_value = COUNT_BOTTOM;
          else nx.count_value = st.count_value + 8'h01;
          if (at_max) set_f[POS_OVERFLOW] = 1'b1;
        end
        MODE_FAST, MODE_FAST_A: begin
          if (at_top) begin
            nx.count_value = COUNT_BOTTOM;
            set_f[POS_OVERFLOW] = 1'b1;
          end else begin
            nx.count_value = st.count_value + 8'h01;
          end
        end
        MODE_PHASE, MODE_PHASE_A: begin
          if (st.count_down) begin
            if (at_bottom) begin
              nx.count_down  = 1'b0;
              nx.count_value = st.count_value + 8'h01;
              set_f[POS_OVERFLOW] = 1'b1;
            end else begin
              nx.count_value = st.count_value - 8'h01;
            end
          end else if (at_top) begin
            nx.count_down  = 1'b1;
            nx.count_value = st.count_value - 8'h01;
          end else begin
            nx.count_value = st.count_value + 8'h01;
          end
        end
        default: nx.count_value = st.count_value + 8'h01;
      endcase
      // load compare values from buffers at top, in phase modes only while counting up
      if (buffered) begin
        if ((waveform_mode == MODE_FAST || waveform_mode == MODE_FAST_A) ? at_top : (at_top && ~st.count_down)) begin
          nx.compare_value_a = st.buffer_a;
          nx.compare_value_b = st.buffer_b;
        end
      end
    end

    if (i_wr) begin
      if (i_addr == ADDR_POWER) begin
        nx.timer_power_off = i_wdata[POS_POWER_OFF];
      end else if (~st.timer_power_off) begin
        case (i_addr)
          ADDR_CONTROL_A: nx.control_a = i_wdata;
          ADDR_CONTROL_B: begin
            nx.control_b = {2'b00, i_wdata[5:0]};
            // forced match moves the output only
            if (~is_pwm({i_wdata[POS_MODE_BIT2], waveform_mode[1:0]})) begin
              if (i_wdata[POS_FORCE_A]) nx.wave_a = apply_com(st.control_a[POS_COM_A +: 2], st.wave_a);
              if (i_wdata[POS_FORCE_B]) nx.wave_b = apply_com(st.control_a[POS_COM_B +: 2], st.wave_b);
            end
          end
          ADDR_COUNT: begin
            nx.count_value = i_wdata;
            nx.block_match = 1'b1;
            nx.pend_a      = 1'b0;
            nx.pend_b      = 1'b0;
          end
          ADDR_COMPARE_A: begin
            if (buffered) nx.buffer_a = i_wdata;
            else nx.compare_value_a = i_wdata;
          end
          ADDR_COMPARE_B: begin
            if (buffered) nx.buffer_b = i_wdata;
            else nx.compare_value_b = i_wdata;
          end
          ADDR_FLAGS:   clr_f = i_wdata[2:0];
          ADDR_MASK:    nx.mask = i_wdata[2:0];
          ADDR_ASYNC:   nx.async_clock_select = i_wdata[POS_ASYNC_SEL];
          ADDR_SERVICE: clr_f = i_wdata[2:0];
          default: ;
        endcase
      end
    end
    if (~buffered && !(i_wr && i_addr inside {ADDR_COMPARE_A, ADDR_COMPARE_B})) begin
      nx.buffer_a = nx.compare_value_a;
      nx.buffer_b = nx.compare_value_b;
    end
    // set wins over clear
    nx.flags = (st.flags & ~clr_f) | set_f;
    nx.irq   = nx.flags & nx.mask;

    if (i_rd) begin
      case (i_addr)
        ADDR_CONTROL_A: rd = st.control_a;
        ADDR_CONTROL_B: rd = st.control_b;
        ADDR_COUNT:     rd = st.count_value;
        ADDR_COMPARE_A: rd = buffered ? st.buffer_a : st.compare_value_a;
        ADDR_COMPARE_B: rd = buffered ? st.buffer_b : st.compare_value_b;
        ADDR_FLAGS:     rd = {5'h00, st.flags};
        ADDR_MASK:      rd = {5'h00, st.mask};
        ADDR_ASYNC:     rd = {2'b00, st.async_clock_select, 5'h00};
        ADDR_POWER:     rd = {7'h00, st.timer_power_off};
        default:        rd = RESET_BYTE;
      endcase
    end
    nx.rdata = rd;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st <= '0;
      st.timer_power_off <= POWER_RESET;
    end else begin
      st <= nx;
    end
  end

  assign o_rdata           = st.rdata;
  assign o_wave_output_a   = st.wave_a;
  assign o_wave_output_b   = st.wave_b;
  assign o_irq_overflow    = st.irq[POS_OVERFLOW];
  assign o_irq_match_a     = st.irq[POS_MATCH_A];
  assign o_irq_match_b     = st.irq[POS_MATCH_B];
  assign o_crystal_pin_out = st.osc_out;

  a_count_write_wins: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_count |=> st.count_value == $past(i_wdata)) else $error("count write lost");
  a_stop_holds_count: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (clock_source_select == CLK_STOPPED && !i_wr) |=> $stable(st.count_value)) else $error("stopped timer moved");
  a_match_flag_late: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && st.pend_a) |=> st.flags[POS_MATCH_A]) else $error("match a flag missing");
  a_block_after_write: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_count |=> !st.pend_a && !st.pend_b) else $error("match not blocked");
  a_normal_overflow: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && waveform_mode == MODE_NORMAL && at_max && !i_wr) |=>
      st.count_value == COUNT_BOTTOM && st.flags[POS_OVERFLOW]) else $error("normal wrap wrong");
  a_match_clear: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && waveform_mode == MODE_CLEAR_ON_MATCH && eq_a && !i_wr) |=> st.count_value == COUNT_BOTTOM)
    else $error("clear on match missing");
  a_irq_masked: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_irq_match_b |-> st.mask[POS_MATCH_B] && st.flags[POS_MATCH_B]) else $error("irq b not masked");
  a_power_off_idle: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    st.timer_power_off |-> !timer_tick) else $error("tick while powered off");
  a_com_off_holds: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (st.control_a[POS_COM_A +: 2] == COM_OFF && !i_wr) |=> $stable(st.wave_a)) else $error("output moved");
  // single slope restart at top
  a_fast_wrap: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && (waveform_mode == MODE_FAST || waveform_mode == MODE_FAST_A) && at_top && !i_wr) |=>
      st.count_value == COUNT_BOTTOM && st.flags[POS_OVERFLOW]) else $error("fast wrap wrong");
  // buffer copied into active compare at top
  a_buffer_load: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && waveform_mode == MODE_FAST_A && at_top && !i_wr) |=>
      st.compare_value_a == $past(st.buffer_a)) else $error("buffer not loaded");
  a_normal_counts_up: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && waveform_mode == MODE_NORMAL && !i_wr) |=>
      st.count_value == $past(st.count_value) + 8'h01) else $error("normal count not up");
  a_idle_count_still: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!timer_tick && !i_wr) |=> $stable(st.count_value)) else $error("count moved without tick");
  a_power_off_frozen: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (st.timer_power_off && !(i_wr && i_addr == ADDR_POWER)) |=>
      $stable(st.count_value) && $stable(st.control_a) && $stable(st.control_b)) else $error("powered off block changed");
  a_force_no_flag: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_wr && i_addr == ADDR_CONTROL_B && !timer_tick) |=> $stable(st.flags)) else $error("force touched flags");
  a_mode_keeps_output: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_wr && i_addr == ADDR_CONTROL_A && !timer_tick) |=> $stable(st.wave_a) && $stable(st.wave_b))
    else $error("output lost on mode change");
  a_match_b_flag_late: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (timer_tick && st.pend_b) |=> st.flags[POS_MATCH_B]) else $error("match b flag missing");
  a_rdata_idle_zero: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_rd |=> o_rdata == RESET_BYTE) else $error("read data without read");
endmodule

/* File: rtl/timer_core_pkg.sv */
// constants and register map of the eight-bit timer core
package timer_core_pkg;
  localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT     = 4'h2;
  localparam logic [3:0] ADDR_COMPARE_A = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_B = 4'h4;
  localparam logic [3:0] ADDR_FLAGS     = 4'h5;
  localparam logic [3:0] ADDR_MASK      = 4'h6;
  localparam logic [3:0] ADDR_ASYNC     = 4'h7;
  localparam logic [3:0] ADDR_POWER     = 4'h8;
  localparam logic [3:0] ADDR_SERVICE   = 4'h9;
  // timer_control_a fields
  localparam int POS_MODE_BIT0 = 0;
  localparam int POS_MODE_BIT1 = 1;
  localparam int POS_COM_B     = 4;
  localparam int POS_COM_A     = 6;
  // timer_control_b fields
  localparam int POS_CLK_SEL   = 0;
  localparam int POS_MODE_BIT2 = 3;
  localparam int POS_FORCE_B   = 6;
  localparam int POS_FORCE_A   = 7;
  // flag and mask bits, then async select and power off bits
  localparam int POS_OVERFLOW  = 0;
  localparam int POS_MATCH_A   = 1;
  localparam int POS_MATCH_B   = 2;
  localparam int POS_ASYNC_SEL = 5;
  localparam int POS_POWER_OFF = 0;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_PHASE   = 3'h1;
  localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST    = 3'h3;
  localparam logic [2:0] MODE_PHASE_A = 3'h5;
  localparam logic [2:0] MODE_FAST_A  = 3'h7;
  localparam logic [2:0] CLK_STOPPED  = 3'h0;
  localparam logic [1:0] COM_OFF      = 2'h0;
  localparam logic [1:0] COM_TOGGLE   = 2'h1;
  localparam logic [1:0] COM_CLEAR    = 2'h2;
  localparam logic [1:0] COM_SET      = 2'h3;
  localparam logic       POWER_RESET  = 1'b0;
endpackage

/* File: tb/crystal_osc_model.sv */
// behavioural crystal oscillator on the timer's crystal pins
`timescale 1ns/100ps
module crystal_osc_model #(
  parameter realtime HALF_PERIOD = 73ns
) (
  input  wire logic i_enable,
  output logic      o_crystal
);
  initial o_crystal = 1'b0;
  // free running while enabled, unrelated to the system clock
  always begin
    #(HALF_PERIOD);
    o_crystal = i_enable ? ~o_crystal : 1'b0;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking testbench of the eight-bit timer core
`timescale 1ns/100ps
module testbench;
  import timer_core_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        xtal_en = 1'b0;
  logic        xtal;
  logic        xtal_out;
  logic [7:0]  rdata;
  logic        wave_a;
  logic        wave_b;
  logic        irq_ovf;
  logic        irq_a;
  logic        irq_b;
  logic [7:0]  q;
  logic [31:0] seed = 32'h8952;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  eight_bit_timer_compare_core eight_bit_timer_compare_core_i (
    .i_clk_sys(clk_sys), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .i_crystal_pin_in(xtal), .o_rdata(rdata), .o_wave_output_a(wave_a), .o_wave_output_b(wave_b),
    .o_irq_overflow(irq_ovf), .o_irq_match_a(irq_a), .o_irq_match_b(irq_b), .o_crystal_pin_out(xtal_out));
  crystal_osc_model crystal_osc_model_i (.i_enable(xtal_en), .o_crystal(xtal));

  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] ctl_a(input logic [2:0] m, input logic [1:0] ca, input logic [1:0] cb);
    return {ca, cb, 2'b00, m[1:0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic run(input int n);
    wr_reg(ADDR_CONTROL_B, 8'h01);
    repeat (n) @(posedge clk_sys);
    wr_reg(ADDR_CONTROL_B, 8'h00);
  endtask
  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 11; a++) begin
      rd_reg(a[3:0], q);
      chk(q, RESET_BYTE);
    end
    // stopped timer keeps written count
    wr_reg(ADDR_COUNT, 8'hf0);
    repeat (20) @(posedge clk_sys);
    rd_reg(ADDR_COUNT, q);
    chk(q, 8'hf0);
    // normal mode wrap past max, compares at zero
    wr_reg(ADDR_MASK, 8'h01);
    run(30);
    rd_reg(ADDR_FLAGS, q);
    chk(q, 8'h07);
    chk({5'h0, irq_b, irq_a, irq_ovf}, 8'h01);
    wr_reg(ADDR_SERVICE, 8'h01);
    rd_reg(ADDR_FLAGS, q);
    chk(q, 8'h06);
    wr_reg(ADDR_FLAGS, 8'h06);
    rd_reg(ADDR_FLAGS, q);
    chk(q, 8'h00);
    // clear on match with compare a as top
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_CLEAR_ON_MATCH, COM_OFF, COM_OFF));
    wr_reg(ADDR_COMPARE_A, 8'h10);
    wr_reg(ADDR_COUNT, 8'h00);
    run(60);
    rd_reg(ADDR_COUNT, q);
    chk({7'h0, q <= 8'h10}, 8'h01);
    rd_reg(ADDR_FLAGS, q);
    chk(q & 8'h02, 8'h02);
    // count write equal to compare b blocks that match
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_NORMAL, COM_OFF, COM_OFF));
    wr_reg(ADDR_COMPARE_B, 8'h20);
    wr_reg(ADDR_COUNT, 8'h20);
    wr_reg(ADDR_FLAGS, 8'h07);
    run(20);
    rd_reg(ADDR_FLAGS, q);
    chk(q, 8'h00);
    // forced compares touch outputs only
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_NORMAL, COM_SET, COM_TOGGLE));
    wr_reg(ADDR_CONTROL_B, 8'hc0);
    repeat (2) @(posedge clk_sys);
    chk({6'h0, wave_b, wave_a}, 8'h03);
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_FAST, COM_OFF, COM_OFF));
    repeat (2) @(posedge clk_sys);
    chk({6'h0, wave_b, wave_a}, 8'h03);
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_NORMAL, COM_CLEAR, COM_TOGGLE));
    wr_reg(ADDR_CONTROL_B, 8'hc0);
    repeat (2) @(posedge clk_sys);
    chk({6'h0, wave_b, wave_a}, 8'h00);
    rd_reg(ADDR_FLAGS, q);
    chk(q, 8'h00);
    // random count and compare values, unbuffered in normal mode
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      wr_reg(ADDR_COMPARE_B, seed[7:0]);
      wr_reg(ADDR_COUNT, seed[15:8]);
      rd_reg(ADDR_COMPARE_B, q);
      chk(q, seed[7:0]);
      rd_reg(ADDR_COUNT, q);
      chk(q, seed[15:8]);
    end
    // power off ignores writes
    wr_reg(ADDR_POWER, 8'h01);
    wr_reg(ADDR_COUNT, 8'h55);
    wr_reg(ADDR_POWER, 8'h00);
    rd_reg(ADDR_COUNT, q);
    chk(q, seed[15:8]);
    // fast pwm with compare a as top, buffered compare
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_FAST_A, COM_OFF, COM_OFF));
    wr_reg(ADDR_COMPARE_A, 8'h08);
    rd_reg(ADDR_COMPARE_A, q);
    chk(q, 8'h08);
    wr_reg(ADDR_COUNT, 8'h00);
    wr_reg(ADDR_FLAGS, 8'h07);
    wr_reg(ADDR_CONTROL_B, 8'h09);
    repeat (40) @(posedge clk_sys);
    wr_reg(ADDR_CONTROL_B, 8'h08);
    rd_reg(ADDR_COUNT, q);
    chk({7'h0, q <= 8'h08}, 8'h01);
    rd_reg(ADDR_FLAGS, q);
    chk(q & 8'h01, 8'h01);
    wr_reg(ADDR_CONTROL_B, 8'h00);
    wr_reg(ADDR_CONTROL_A, ctl_a(MODE_NORMAL, COM_OFF, COM_OFF));
    rd_reg(ADDR_COMPARE_A, q);
    chk(q, 8'h08);
    chk({7'h0, xtal_out}, 8'h00);
    // ticks from crystal edges
    wr_reg(ADDR_ASYNC, 8'h20);
    xtal_en <= 1'b1;
    wr_reg(ADDR_COUNT, 8'h00);
    run(100);
    xtal_en <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({7'h0, xtal_out}, 8'h01);
    rd_reg(ADDR_COUNT, q);
    chk({7'h0, q >= 8'h08 && q <= 8'h14}, 8'h01);
    summarize();
  end
endmodule
